// ==== lmp_defines.svh ====
// constants for the status lamp pattern generator
`ifndef LMP_DEFINES_SVH
`define LMP_DEFINES_SVH

// clock rate and pattern times
`define LMP_CLK_KHZ      125000
`define LMP_FAST_MS      300
`define LMP_SLOW_ON_MS   600
`define LMP_SLOW_OFF_MS  2400
`define LMP_TEST_MS      1500
// one blink unit is the fast half period, in cycles
`define LMP_UNIT_CYC     (`LMP_FAST_MS * `LMP_CLK_KHZ)

// register byte offsets
`define LMP_CTRL_OFS     12'h000
`define LMP_STAT_OFS     12'h004
`define LMP_ISTAT_OFS    12'h008
`define LMP_IMASK_OFS    12'h00C

// control fields and reset values
`define LMP_CTRL_EN_BIT  0
`define LMP_CTRL_RST     1'h1
`define LMP_IMASK_RST    3'h0

// status fields
`define LMP_STAT_TEST_BIT  4
`define LMP_STAT_GRN_BIT   5
`define LMP_STAT_RED_BIT   6

// interrupt event bits
`define LMP_IRQ_TEST     0
`define LMP_IRQ_FATAL    1
`define LMP_IRQ_MODE     2
`define LMP_IRQ_W        3

`endif

// ==== lmp_lamp_gen.sv ====
// two-lamp status pattern generator with apb registers
`timescale 1ns/1ps
`default_nettype none
`include "lmp_defines.svh"

module lmp_lamp_gen #(
  parameter int UNIT_CYC = `LMP_UNIT_CYC // cycles per 0.3 s unit
) (
  input  wire logic                 core_clk,  // system clock
  input  wire logic                 rst_n,     // async reset, low
  input  wire lmp_pkg::lmp_apb_req_t apbReq,   // apb request
  output var lmp_pkg::lmp_apb_rsp_t apbRsp,    // apb answer
  input  wire lmp_pkg::lmp_cond_t   cond,      // condition flags
  output logic                      greenLamp, // ready lamp drive
  output logic                      redLamp,   // error lamp drive
  output logic                      irq        // level interrupt
);
  import lmp_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // unit counts derived from the printed times
  localparam int SLOW_ON = `LMP_SLOW_ON_MS / `LMP_FAST_MS;
  localparam int SLOW_P  = (`LMP_SLOW_ON_MS + `LMP_SLOW_OFF_MS)
                           / `LMP_FAST_MS;
  localparam int TEST_U  = `LMP_TEST_MS / `LMP_FAST_MS;

  // fast blink uses slot parity, so the period must be even
  if (UNIT_CYC < 1 || SLOW_P > 16 || (SLOW_P % 2) != 0 ||
      TEST_U > 16 || TEST_U < 1 ||
      (`LMP_SLOW_ON_MS % `LMP_FAST_MS) != 0 ||
      (`LMP_SLOW_OFF_MS % `LMP_FAST_MS) != 0 ||
      (`LMP_TEST_MS % `LMP_FAST_MS) != 0) begin : g_chk
    $error("lmp_lamp_gen: timing values not servable");
  end

  localparam logic [31:0] UNIT_LAST = 32'(UNIT_CYC - 1);
  localparam logic [3:0]  SLOT_LAST = 4'(SLOW_P - 1);
  localparam logic [3:0]  SLOW_ONU  = 4'(SLOW_ON);
  localparam logic [3:0]  TEST_LAST = 4'(TEST_U - 1);

  lmp_state_t q;
  lmp_state_t d;

  // combinational helpers, visible to the checks below
  logic      unitEnd;
  logic      fastOn;
  logic      slowOn;
  lmp_mode_t want;
  logic      setupRd;
  logic      access;
  logic      mapped;
  logic [2:0] ev;

  ////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic [2:0] clr;
    clr     = 3'h0;
    d       = q;
    unitEnd = (q.unitCnt == UNIT_LAST);
    fastOn  = ~q.slot[0];
    slowOn  = (q.slot < SLOW_ONU);
    ev      = 3'h0;

    if (cond.fatal) begin
      want = MD_FATAL;
    end else if (cond.engineErr) begin
      want = MD_ENGINE;
    end else if (cond.bothOnErr) begin
      want = MD_BOTHON;
    end else if (cond.protoErr) begin
      want = MD_PROTO;
    end else if (cond.recovErr) begin
      want = MD_RECOV;
    end else if (cond.consumWarn) begin
      want = MD_WARN;
    end else if (cond.busy || cond.ramCheck) begin
      want = MD_BUSY;
    end else if (cond.ready) begin
      want = MD_READY;
    end else begin
      want = MD_OFF;
    end

    if (unitEnd) begin
      d.unitCnt = 32'h0;
      d.slot    = (q.slot == SLOT_LAST) ? 4'h0 : q.slot + 4'h1;
    end else begin
      d.unitCnt = q.unitCnt + 32'h1;
    end

    if (q.mode == MD_TEST) begin
      // lamp test ends after its units
      if (unitEnd && q.slot == TEST_LAST) begin
        d.mode    = want;
        d.slot    = 4'h0;
        ev[`LMP_IRQ_TEST] = 1'b1;
      end
    end else if (want != q.mode) begin
      // restart at start of lit phase
      d.mode    = want;
      d.unitCnt = 32'h0;
      d.slot    = 4'h0;
      ev[`LMP_IRQ_MODE] = 1'b1;
    end
    ev[`LMP_IRQ_FATAL] = (d.mode == MD_FATAL) && (q.mode != MD_FATAL);

    // lamp drive from current pattern and phase
    unique case (q.mode)
      MD_TEST: begin
        d.green = 1'b1;
        d.red   = 1'b1;
      end
      MD_OFF: begin
        d.green = 1'b0;
        d.red   = 1'b0;
      end
      MD_READY: begin
        d.green = 1'b1;
        d.red   = 1'b0;
      end
      MD_BUSY: begin
        d.green = fastOn;
        d.red   = 1'b0;
      end
      MD_WARN: begin
        d.green = slowOn;
        d.red   = 1'b0;
      end
      MD_RECOV: begin
        d.green = 1'b1;
        d.red   = fastOn;
      end
      MD_PROTO: begin
        d.green = fastOn;
        d.red   = 1'b1;
      end
      MD_BOTHON: begin
        d.green = 1'b1;
        d.red   = 1'b1;
      end
      MD_ENGINE: begin
        d.green = fastOn;
        d.red   = ~fastOn;
      end
      MD_FATAL: begin
        d.green = 1'b0;
        d.red   = 1'b1;
      end
    endcase
    // software blanking never hides the power-on test
    if (!q.lampEn && q.mode != MD_TEST) begin
      d.green = 1'b0;
      d.red   = 1'b0;
    end

    // apb: read data latched in setup, so access needs no wait
    setupRd = apbReq.psel && !apbReq.penable && !apbReq.pwrite;
    access  = apbReq.psel && apbReq.penable;
    mapped  = apbReq.paddr == `LMP_CTRL_OFS ||
              apbReq.paddr == `LMP_STAT_OFS ||
              apbReq.paddr == `LMP_ISTAT_OFS ||
              apbReq.paddr == `LMP_IMASK_OFS;
    if (setupRd) begin
      d.prdata = 32'h0;
      unique case (apbReq.paddr)
        `LMP_CTRL_OFS:  d.prdata[`LMP_CTRL_EN_BIT] = q.lampEn;
        `LMP_STAT_OFS: begin
          d.prdata[3:0] = q.mode;
          d.prdata[`LMP_STAT_TEST_BIT] = (q.mode == MD_TEST);
          d.prdata[`LMP_STAT_GRN_BIT]  = q.green;
          d.prdata[`LMP_STAT_RED_BIT]  = q.red;
        end
        `LMP_ISTAT_OFS: d.prdata[2:0] = q.irqStat;
        `LMP_IMASK_OFS: d.prdata[2:0] = q.irqMask;
        default:        d.prdata = 32'h0;
      endcase
    end
    if (access && apbReq.pwrite) begin
      unique case (apbReq.paddr)
        `LMP_CTRL_OFS:
          d.lampEn = apbReq.pwdata[`LMP_CTRL_EN_BIT];
        `LMP_ISTAT_OFS: clr = apbReq.pwdata[2:0];
        `LMP_IMASK_OFS: d.irqMask = apbReq.pwdata[2:0];
        default: ;
      endcase
    end
    // a new event wins over a write-one clear
    d.irqStat = (q.irqStat & ~clr) | ev;
  end

  ////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q.mode    <= MD_TEST;
      q.unitCnt <= 32'h0;
      q.slot    <= 4'h0;
      q.lampEn  <= `LMP_CTRL_RST;
      q.irqStat <= 3'h0;
      q.irqMask <= `LMP_IMASK_RST;
      q.prdata  <= 32'h0;
      q.green   <= 1'b1;
      q.red     <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // outputs
  assign greenLamp      = q.green;
  assign redLamp        = q.red;
  assign irq            = |(q.irqStat & q.irqMask);
  // one driver for the whole answer struct
  assign apbRsp         = '{pready:  access,
                            pslverr: access && !mapped,
                            prdata:  q.prdata};

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  logic live;
  assign live = q.lampEn && q.mode != MD_TEST;

  property p_fast;
    (q.mode == MD_BUSY && live) |=> (greenLamp == $past(fastOn))
                                    && !redLamp;
  endproperty
  a_fast: assert property (p_fast)
    else $error("busy pattern not a fast green blink");

  property p_slow;
    (q.mode == MD_WARN && live && q.slot == 4'h2)
      |=> !greenLamp && !redLamp;
  endproperty
  a_slow: assert property (p_slow)
    else $error("slow blink lit past its on time");

  property p_test;
    (q.mode == MD_TEST) |=> greenLamp && redLamp;
  endproperty
  a_test: assert property (p_test)
    else $error("lamp test not lighting both lamps");

  property p_test_len;
    $fell(q.mode == MD_TEST) |-> $past(q.slot) == TEST_LAST
                                 && $past(unitEnd);
  endproperty
  a_test_len: assert property (p_test_len)
    else $error("lamp test ended at wrong time");

  property p_fatal;
    (cond.fatal && q.mode != MD_TEST && q.lampEn)
      |=> q.mode == MD_FATAL ##1 (!greenLamp && redLamp);
  endproperty
  a_fatal: assert property (p_fatal)
    else $error("fatal condition not shown red only");

  property p_engine;
    (q.mode == MD_ENGINE && live) |=> greenLamp != redLamp;
  endproperty
  a_engine: assert property (p_engine)
    else $error("engine error lamps not alternating");

  property p_bothon;
    (q.mode == MD_BOTHON && live) |=> greenLamp && redLamp;
  endproperty
  a_bothon: assert property (p_bothon)
    else $error("both-on error not lighting both");

  property p_restart;
    ($changed(q.mode) && $past(q.mode) != MD_TEST)
      |-> q.slot == 4'h0 && q.unitCnt == 32'h0;
  endproperty
  a_restart: assert property (p_restart)
    else $error("new pattern did not start at lit phase");

  property p_rank;
    (cond.engineErr && !cond.fatal && q.mode != MD_TEST)
      |=> q.mode == MD_ENGINE;
  endproperty
  a_rank: assert property (p_rank)
    else $error("engine error not ranked above milder ones");

  property p_ready;
    (q.mode == MD_READY && live) |=> greenLamp && !redLamp;
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready pattern wrong");

  property p_fast_dark;
    (q.mode == MD_BUSY && live && q.slot[0]) |=> !greenLamp && !redLamp;
  endproperty
  a_fast_dark: assert property (p_fast_dark)
    else $error("busy pattern lit in its dark phase");

  property p_warn_lit;
    (q.mode == MD_WARN && live && q.slot <= 4'h1)
      |=> greenLamp && !redLamp;
  endproperty
  a_warn_lit: assert property (p_warn_lit)
    else $error("slow blink dark during its on time");

  property p_recov;
    (q.mode == MD_RECOV && live)
      |=> greenLamp && (redLamp == !$past(q.slot[0]));
  endproperty
  a_recov: assert property (p_recov)
    else $error("recoverable error not green on, red blinking");

  property p_ramchk;
    (cond.ramCheck && cond[8:2] == 7'h00 && q.mode != MD_TEST)
      |=> q.mode == MD_BUSY;
  endproperty
  a_ramchk: assert property (p_ramchk)
    else $error("memory check not shown as green fast blink");

endmodule // lmp_lamp_gen
`default_nettype wire

// ==== lmp_lamp_view.sv ====
// front-panel viewer that times the lit and dark runs of one lamp
`timescale 1ns/1ps
`default_nettype none

module lmp_lamp_view (
  input  wire logic   core_clk, // system clock
  input  wire logic   rst_n,    // async reset, low
  input  wire logic   lamp,     // lamp drive, high=lit
  output logic [15:0] lastOn,   // last full lit run
  output logic [15:0] lastOff,  // last full dark run
  output logic [15:0] runLen    // cycles at current level
);
  logic prev_q;

  // a run closes where the level flips; the count saturates, no wrap
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q  <= 1'b1;
      lastOn  <= 16'h0000;
      lastOff <= 16'h0000;
      runLen  <= 16'h0000;
    end else if (lamp !== prev_q) begin
      prev_q <= lamp;
      runLen <= 16'h0001;
      if (prev_q) lastOn <= runLen;
      else lastOff <= runLen;
    end else if (runLen != 16'hFFFF) begin
      runLen <= runLen + 16'h0001;
    end
  end
endmodule // lmp_lamp_view
`default_nettype wire

// ==== lmp_pkg.sv ====
// types for the status lamp pattern generator
package lmp_pkg;

  // shown lamp pattern, mildest first
  typedef enum logic [3:0] {
    MD_TEST, MD_OFF, MD_READY, MD_BUSY, MD_WARN,
    MD_RECOV, MD_PROTO, MD_BOTHON, MD_ENGINE, MD_FATAL
  } lmp_mode_t;

  // printer condition flags, same clock
  typedef struct packed {
    logic fatal;
    logic engineErr;
    logic bothOnErr;
    logic protoErr;
    logic recovErr;
    logic consumWarn;
    logic busy;
    logic ramCheck;
    logic ready;
  } lmp_cond_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } lmp_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } lmp_apb_rsp_t;

  // whole module state
  typedef struct packed {
    lmp_mode_t   mode;
    logic [31:0] unitCnt;
    logic [3:0]  slot;
    logic        lampEn;
    logic [2:0]  irqStat;
    logic [2:0]  irqMask;
    logic [31:0] prdata;
    logic        green;
    logic        red;
  } lmp_state_t;

endpackage

// ==== status_lamp_pattern_generator_tb.sv ====
// self-checking bench for the lamp pattern generator
`timescale 1ns/1ps
`default_nettype none
`include "lmp_defines.svh"

module status_lamp_pattern_generator_tb;
  import lmp_pkg::*;
  localparam int U = 4; // short unit keeps the run brief
  logic         core_clk = 1'b0;
  logic         rst_n    = 1'b0;
  lmp_apb_req_t apbReq   = '0;
  lmp_apb_rsp_t apbRsp;
  lmp_cond_t    cond     = '0;
  logic         greenLamp, redLamp, irq, err;
  logic [15:0]  gOnL, gOffL, gRun, rOnL, rOffL, rRun;
  logic [31:0]  rd;
  int           fails = 0;
  int           num_checks = 0;

  always #4 core_clk = ~core_clk;

  lmp_lamp_gen #(.UNIT_CYC(U)) lmp_lamp_gen_inst (.core_clk(core_clk),
    .rst_n(rst_n), .apbReq(apbReq), .apbRsp(apbRsp), .cond(cond),
    .greenLamp(greenLamp), .redLamp(redLamp), .irq(irq));
  lmp_lamp_view lmp_lamp_view_inst_grn (.core_clk(core_clk), .rst_n(rst_n),
    .lamp(greenLamp), .lastOn(gOnL), .lastOff(gOffL), .runLen(gRun));
  lmp_lamp_view lmp_lamp_view_inst_red (.core_clk(core_clk), .rst_n(rst_n),
    .lamp(redLamp), .lastOn(rOnL), .lastOff(rOffL), .runLen(rRun));

  task automatic check(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge core_clk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (apbRsp.pready !== 1'b1 && n < 50);
    check("pready", apbRsp.pready, 1'b1);
    rd  = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq.psel    <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask

  task automatic set_cond(input logic [8:0] v);
    @(posedge core_clk);
    cond <= lmp_cond_t'(v);
  endtask

  // eOff of 0 means a steady lamp at level eOn
  task automatic lamp_ok(input string nm, input logic lamp,
                         input logic [15:0] onL, offL, run,
                         input int eOn, eOff);
    if (eOff == 0) begin
      check(nm, lamp, eOn);
      check(nm, run >= 90, 1);
    end else begin
      check(nm, onL, eOn);
      check(nm, offL, eOff);
      // a steady lamp would leave stale run lengths from the last mode
      check(nm, run <= eOn + eOff, 1);
    end
  endtask

  task automatic do_mode(input string nm, input logic [8:0] v,
                         input logic [1:0] st, input int gOn, gOff,
                         input int rOn, rOff, input logic opp);
    int eq;
    logic [1:0] first;
    eq = 0;
    first = 2'b00;
    set_cond(v);
    for (int k = 0; k < 100; k++) begin
      @(posedge core_clk);
      #1;
      if (k == 1) first = {greenLamp, redLamp};
      if (k > 2 && greenLamp === redLamp) eq++;
    end
    check({nm, " start"}, first, st);
    lamp_ok({nm, " green"}, greenLamp, gOnL, gOffL, gRun, gOn, gOff);
    lamp_ok({nm, " red"}, redLamp, rOnL, rOffL, rRun, rOn, rOff);
    if (opp) check({nm, " phase"}, eq, 0);
    $display("test %s done", nm);
  endtask

  task automatic test_power_on;
    int n;
    n = 0;
    check("reset lamps", {greenLamp, redLamp}, 2'b11);
    @(posedge core_clk);
    rst_n <= 1'b1;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (greenLamp === 1'b1 && n < 100);
    check("test length", n >= 5 * U && n <= 5 * U + 3, 1);
    check("dark after test", {greenLamp, redLamp}, 2'b00);
    $display("test power_on done");
  endtask

  task automatic test_regs_irq;
    apb(1'b0, `LMP_CTRL_OFS, 32'h0);
    check("ctrl reset", rd, 32'h1);
    apb(1'b0, `LMP_IMASK_OFS, 32'h0);
    check("mask reset", rd, 32'h0);
    apb(1'b0, `LMP_ISTAT_OFS, 32'h0);
    check("test done event", rd[0], 1'b1);
    check("masked irq", irq, 1'b0);
    set_cond(9'h001);
    apb(1'b1, `LMP_CTRL_OFS, 32'h0);
    repeat (3) @(posedge core_clk);
    #1 check("blanked", {greenLamp, redLamp}, 2'b00);
    apb(1'b1, `LMP_CTRL_OFS, 32'h1);
    apb(1'b1, `LMP_ISTAT_OFS, 32'h7);
    apb(1'b0, `LMP_ISTAT_OFS, 32'h0);
    check("cleared", rd[2:0], 3'h0);
    apb(1'b1, `LMP_IMASK_OFS, 32'h2);
    set_cond(9'h100);
    repeat (3) @(posedge core_clk);
    #1 check("fatal irq", irq, 1'b1);
    apb(1'b1, `LMP_ISTAT_OFS, 32'h2);
    repeat (2) @(posedge core_clk);
    #1 check("irq cleared", irq, 1'b0);
    apb(1'b0, 12'h010, 32'h0);
    check("unmapped err", err, 1'b1);
    check("unmapped data", rd, 32'h0);
    $display("test regs_irq done");
  endtask

  task automatic test_priority;
    int ex[10] = '{9, 8, 7, 6, 5, 4, 3, 3, 2, 1};
    for (int i = 0; i < 10; i++) begin
      set_cond(9'h1FF >> i);
      repeat (3) @(posedge core_clk);
      apb(1'b0, `LMP_STAT_OFS, 32'h0);
      check("shown mode", rd[3:0], ex[i]);
    end
    $display("test priority done");
  endtask

  initial begin
    repeat (2) @(posedge core_clk);
    test_power_on();
    test_regs_irq();
    do_mode("busy", 9'h004, 2'b10, U, U, 0, 0, 0);
    do_mode("ready", 9'h001, 2'b10, 1, 0, 0, 0, 0);
    do_mode("ramcheck", 9'h002, 2'b10, U, U, 0, 0, 0);
    do_mode("warn", 9'h008, 2'b10, 2 * U, 8 * U, 0, 0, 0);
    do_mode("engine", 9'h080, 2'b10, U, U, U, U, 1);
    do_mode("recov", 9'h010, 2'b11, 1, 0, U, U, 0);
    do_mode("bothon", 9'h040, 2'b11, 1, 0, 1, 0, 0);
    do_mode("fatal", 9'h100, 2'b01, 0, 0, 1, 0, 0);
    do_mode("proto", 9'h020, 2'b11, U, U, 1, 0, 0);
    test_priority();
    tally_and_finish();
  end

  // cuts a hang short well past the expected run length
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    $display("[ERR] watchdog expected done seen timeout");
    tally_and_finish();
  end
endmodule // status_lamp_pattern_generator_tb
`default_nettype wire
